//--- verilog/sfc_cmd_status_regs.sv
// Purpose: Command and status register pair of a storage host function's configuration header.
// Assumes: Event, request and mode inputs come from logic on mclk; no synchronisers are needed.
// Notes:   Reads and writes take one cycle; cfg_ack answers every access, mapped or not.

`timescale 1ns/1ps
`default_nettype none

// Function
// - Interrupt disable blocks line and message interrupts.
// - Unused command enables read as zero.
// - Parity error pin only when response enabled.
// - Bus master starts only when enabled.
// - Memory space enable stays zero.
// - I/O decode only when I/O enabled.
// - Command resets zero, upper bits reserved.
// - Status bits fifteen and thirteen clear by writing one; bit eight only by reset.
// - Host parity error sets bit fifteen.
// - Master abort sets bit thirteen.
// - Select timing field reads binary 01.
// - Backbone read parity error sets bit eight when response enabled.
// - Capability bits fixed one, others zero.
// - Capability chain bit reads zero.
// - Status bit three shows pending interrupt.
// - Status resets 02A0h, low bits reserved.
module sfc_cmd_status_regs (
  input  wire logic                           mclk,           // Core clock, 20 MHz.
  input  wire logic                           nrst,           // Asynchronous reset, active low.
  input  wire logic                           cfg_rd,         // Configuration read strobe.
  input  wire logic                           cfg_wr,         // Configuration write strobe.
  input  wire logic [sfc_pkg::SFC_AW-1:0]     cfg_addr,       // Configuration byte address.
  input  wire logic [3:0]                     cfg_be,         // Byte enables, bit 0 is the low byte.
  input  wire logic [31:0]                    cfg_wdata,      // Write data.
  output logic      [31:0]                    cfg_rdata,      // Read data, registered.
  output logic                                cfg_ack,        // Access done pulse.
  input  wire logic                           host_par_err,   // Data parity error on host side.
  input  wire logic                           master_abort,   // Bus master transfer ended by abort.
  input  wire logic                           backbone_perr,  // Backbone read completion with bad parity.
  input  wire logic [sfc_pkg::SFC_NCHAN-1:0]  chan_irq_req,   // Per-channel interrupt request levels.
  input  wire logic                           legacy_mode,    // Channels run in legacy mode.
  input  wire logic                           msi_enable,     // Message interrupts enabled.
  input  wire logic                           bm_req,         // Channel asks to start a bus master transfer.
  input  wire logic                           io_hit,         // Access hits a channel or bus master I/O range.
  output logic                                bm_start,       // Bus master transfer may start.
  output logic                                io_claim,       // Claim the I/O access.
  output logic                                bus_master_en,  // Bus master enable level.
  output logic                                perr_n_o,       // Parity error pin output value.
  output logic                                perr_oe,        // Parity error pin drive enable.
  output logic                                intx_n,         // Native interrupt line, active low.
  output logic      [sfc_pkg::SFC_NCHAN-1:0]  legacy_channel_interrupts,  // Legacy channel lines.
  output logic                                msi_req         // Message interrupt request pulse.
);
  import sfc_pkg::*;

  sfc_state_t            s_q;       // Registered state.
  sfc_state_t            s_d;       // Next state.
  logic [SFC_NFLAGS-1:0] flag_set;  // Event set strobes to the flag bank.
  logic [SFC_NFLAGS-1:0] flag_clr;  // Software clear strobes to the flag bank.
  logic [SFC_NFLAGS-1:0] flags;     // Current sticky flags.
  logic                  hit;       // Access addresses the register dword.
  logic                  wr_hit;    // Write to the register dword.
  logic                  pend;      // Any channel requests an interrupt.
  logic [15:0]           cmd_val;   // Command register read value.
  logic [15:0]           sts_val;   // Status register read value.

  // Dword decode, shared by reads and writes.
  function automatic logic dw_hit(input logic [SFC_AW-1:0] a);
    dw_hit = (a[SFC_AW-1:2] == SFC_CMD_OFS[SFC_AW-1:2]);
  endfunction : dw_hit

  // Byte lane of a bit in the dword, so a write only touches lanes enabled.
  function automatic logic lane_on(input logic [3:0] be, input int unsigned bitpos);
    lane_on = be[bitpos / 8];
  endfunction : lane_on

  assign hit    = dw_hit(cfg_addr);
  assign wr_hit = cfg_wr & hit;
  assign pend   = |chan_irq_req;

  // Event sources. The master parity flag only sets while parity response is on.
  always_comb begin
    flag_set               = '0;
    flag_set[SFC_FLAG_DPE] = host_par_err;
    flag_set[SFC_FLAG_RMA] = master_abort;
    flag_set[SFC_FLAG_MPE] = backbone_perr & s_q.parity_response_enable;
  end

  // Write-one-to-clear strobes. The master parity flag is read-only and only reset clears it.
  always_comb begin
    flag_clr               = '0;
    flag_clr[SFC_FLAG_DPE] = wr_hit & lane_on(cfg_be, SFC_STS_SHIFT + SFC_STS_DPE)
                             & cfg_wdata[SFC_STS_SHIFT + SFC_STS_DPE];
    flag_clr[SFC_FLAG_RMA] = wr_hit & lane_on(cfg_be, SFC_STS_SHIFT + SFC_STS_RMA)
                             & cfg_wdata[SFC_STS_SHIFT + SFC_STS_RMA];
  end

  // Sticky flag storage; set wins over a clear in the same cycle.
  sfc_flag_bank u_flags (
    .mclk     (mclk),
    .nrst     (nrst),
    .flag_set (flag_set),
    .flag_clr (flag_clr),
    .flag_q   (flags)
  );

  // Command read value: only the stored enables; every other bit is zero.
  always_comb begin
    cmd_val                  = SFC_CMD_RESET;
    cmd_val[SFC_CMD_IO_SPACE_ENABLE]    = s_q.io_space_enable;
    cmd_val[SFC_CMD_BME]     = s_q.bus_master_enable;
    cmd_val[SFC_CMD_PER]     = s_q.parity_response_enable;
    cmd_val[SFC_CMD_INT_DIS] = s_q.int_dis;
  end

  // Status read value: fixed capability bits plus live flags.
  always_comb begin
    sts_val               = SFC_STS_FIXED;
    sts_val[SFC_STS_DPE]  = flags[SFC_FLAG_DPE];
    sts_val[SFC_STS_RMA]  = flags[SFC_FLAG_RMA];
    sts_val[SFC_STS_MPE]  = flags[SFC_FLAG_MPE];
    // Pending state is shown whatever the disable bit says.
    sts_val[SFC_STS_INTP] = s_q.pend;
  end

  // Next state: register writes, reads, interrupt and parity pin logic.
  always_comb begin
    s_d         = s_q;
    s_d.ack     = cfg_rd | cfg_wr;
    s_d.msi_req = 1'b0;

    // Only writable command bits take write data; fixed bits never store.
    if (wr_hit) begin
      if (lane_on(cfg_be, SFC_CMD_IO_SPACE_ENABLE)) begin
        s_d.io_space_enable = cfg_wdata[SFC_CMD_IO_SPACE_ENABLE];
        s_d.bus_master_enable  = cfg_wdata[SFC_CMD_BME];
        s_d.parity_response_enable  = cfg_wdata[SFC_CMD_PER];
      end
      if (lane_on(cfg_be, SFC_CMD_INT_DIS)) begin
        s_d.int_dis = cfg_wdata[SFC_CMD_INT_DIS];
      end
    end

    // Reads return the dword; an unmapped dword reads as zero.
    if (cfg_rd) begin
      if (hit) begin
        s_d.rdata = {sts_val, cmd_val};
      end else begin
        s_d.rdata = '0;
      end
    end

    // Pending level is registered so its rising edge can send one message.
    s_d.pend = pend;

    // The disable bit gates the pending level before any line or message.
    s_d.intx_n  = ~(pend & ~s_q.int_dis & ~legacy_mode & ~msi_enable);
    s_d.irq     = chan_irq_req & {SFC_NCHAN{~s_q.int_dis & legacy_mode}};
    s_d.msi_req = pend & ~s_q.pend & ~s_q.int_dis & msi_enable;

    // The error pin is driven only while parity response is on.
    s_d.perr_oe = host_par_err & s_q.parity_response_enable;
  end

  // State register; everything returns to its default under reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q        <= '0;
      s_q.intx_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Handshake terms stay combinational so a request is gated the same cycle.
  assign bm_start = bm_req & s_q.bus_master_enable;
  assign io_claim = io_hit & s_q.io_space_enable;

  // Software is expected to place the bus master base before enabling I/O;
  // no ordering is enforced here.

  assign cfg_rdata                 = s_q.rdata;
  assign cfg_ack                   = s_q.ack;
  assign bus_master_en             = s_q.bus_master_enable;
  assign perr_n_o                  = ~s_q.perr_oe;
  assign perr_oe                   = s_q.perr_oe;
  assign intx_n                    = s_q.intx_n;
  assign legacy_channel_interrupts = s_q.irq;
  assign msi_req                   = s_q.msi_req;

  // Checks on the behaviour above.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Disabled function never pulls the native line low.
  a_intx_disabled: assert property (s_q.int_dis |=> intx_n)
    else $error("native interrupt asserted while disabled");

  // A message is never sent right after disable was set.
  a_msi_blocked: assert property (msi_req |-> !$past(s_q.int_dis))
    else $error("message interrupt sent while disabled");

  // Legacy lines follow the channel requests when enabled.
  a_legacy_follow: assert property (legacy_mode && !s_q.int_dis |=>
      legacy_channel_interrupts == $past(chan_irq_req))
    else $error("legacy interrupt lines do not follow requests");

  // Fixed command bits read as zero.
  a_cmd_fixed_zero: assert property (cfg_rd && hit |=> (cfg_rdata[15:0] & ~SFC_CMD_WMASK) == 16'h0000)
    else $error("fixed command bit read nonzero");

  // Fixed status bits read their constants.
  a_sts_fixed: assert property (cfg_rd && hit |=>
      (cfg_rdata[31:16] & ~SFC_STS_DYN) == SFC_STS_FIXED)
    else $error("fixed status bits wrong");

  // Parity pin follows the error only with response enabled.
  a_perr_gate: assert property (host_par_err |=> perr_oe == $past(s_q.parity_response_enable))
    else $error("parity pin drive does not match response enable");

  // Clearing bus master enable stops starts at once.
  a_bm_gate: assert property (wr_hit && cfg_be[0] && !cfg_wdata[SFC_CMD_BME] |=> !bm_start)
    else $error("bus master start while disabled");

  // Clearing I/O enable stops claims at once.
  a_io_gate: assert property (wr_hit && cfg_be[0] && !cfg_wdata[SFC_CMD_IO_SPACE_ENABLE] |=> !io_claim)
    else $error("I/O claimed while disabled");

  // Host parity error shows in the next read.
  a_dpe_set: assert property (host_par_err ##1 cfg_rd && hit && !flag_clr[SFC_FLAG_DPE]
      |=> cfg_rdata[SFC_STS_SHIFT + SFC_STS_DPE])
    else $error("parity error flag not set");

  // Master abort sets its flag.
  a_rma_set: assert property (master_abort |=> flags[SFC_FLAG_RMA])
    else $error("master abort flag not set");

  // Clear by writing one, unless a new event arrives.
  a_w1c_clear: assert property (flag_clr[SFC_FLAG_RMA] && !master_abort |=> !flags[SFC_FLAG_RMA])
    else $error("write one did not clear flag");

  // Backbone error without response enable leaves the flag alone.
  a_mpe_gate: assert property (!s_q.parity_response_enable && !flags[SFC_FLAG_MPE] |=> !flags[SFC_FLAG_MPE])
    else $error("master parity flag set without response enable");

  // Status bit three tracks the pending level.
  a_intp_track: assert property (cfg_rd && hit |=> cfg_rdata[SFC_STS_SHIFT + SFC_STS_INTP] == $past(s_q.pend))
    else $error("pending status does not match");

  // The checks below pin each fixed field of a read separately, so a broken
  // constant points at one field instead of at the whole dword. They also
  // cover the gates and pulse shapes that the bench only samples coarsely.

  // Memory space enable never reads back as one.
  a_mse_zero: assert property (cfg_rd && hit |=> !cfg_rdata[1])
    else $error("memory space enable read nonzero");

  // Reserved upper command bits read as zero.
  a_cmd_resv: assert property (cfg_rd && hit |=> cfg_rdata[15:11] == 5'h00)
    else $error("reserved command bits read nonzero");

  // Unused command enables read as zero.
  a_cmd_unused: assert property (cfg_rd && hit |=> cfg_rdata[9:7] == 3'h0 && cfg_rdata[5:3] == 3'h0)
    else $error("unused command enable read nonzero");

  // Select timing field reads binary 01.
  a_sel_timing: assert property (cfg_rd && hit |=> cfg_rdata[26:25] == 2'h1)
    else $error("select timing field wrong");

  // Both capability bits read as one.
  a_cap_bits: assert property (cfg_rd && hit |=> cfg_rdata[23] && cfg_rdata[21])
    else $error("capability bits not set");

  // Capability chain indicator reads as zero.
  a_cap_chain: assert property (cfg_rd && hit |=> !cfg_rdata[20])
    else $error("capability chain bit set");

  // Reserved low status bits read as zero.
  a_sts_resv: assert property (cfg_rd && hit |=> cfg_rdata[18:16] == 3'h0)
    else $error("reserved status bits read nonzero");

  // An unmapped dword reads as zero.
  a_unmapped_zero: assert property (cfg_rd && !hit |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  // Every access is answered one cycle later.
  a_ack_pulse: assert property (cfg_rd || cfg_wr |=> cfg_ack)
    else $error("access not acknowledged");

  // The disable bit stores what its lane writes.
  a_int_dis_store: assert property (wr_hit && cfg_be[1] |=>
      s_q.int_dis == $past(cfg_wdata[SFC_CMD_INT_DIS]))
    else $error("interrupt disable not stored");

  // A bus master start needs the enable level.
  a_bm_level: assert property (bm_start |-> bus_master_en)
    else $error("bus master start without enable");

  // An I/O claim needs the stored decode enable.
  a_io_level: assert property (io_claim |-> s_q.io_space_enable)
    else $error("I/O claim without enable");

  // A driven parity pin always shows the error level.
  a_perr_pin: assert property (perr_oe |-> !perr_n_o)
    else $error("parity pin driven high");

  // A message request is a single-cycle pulse.
  a_msi_one: assert property (msi_req |=> !msi_req)
    else $error("message request longer than one cycle");

  // The native line is used only outside legacy and message routing.
  a_intx_route: assert property (!intx_n |-> !$past(legacy_mode) && !$past(msi_enable))
    else $error("native line asserted on another route");

  // Disabled function keeps legacy lines low.
  a_legacy_off: assert property (s_q.int_dis |=> legacy_channel_interrupts == '0)
    else $error("legacy line asserted while disabled");

  // Backbone parity error with response enabled sets the flag.
  a_mpe_set: assert property (backbone_perr && s_q.parity_response_enable |=> flags[SFC_FLAG_MPE])
    else $error("master parity flag not set");

  // Host parity flag stays set until written with one.
  a_dpe_hold: assert property (flags[SFC_FLAG_DPE] && !flag_clr[SFC_FLAG_DPE] |=> flags[SFC_FLAG_DPE])
    else $error("parity error flag lost");

  // Pending level is registered one cycle behind the requests.
  a_pend_reg: assert property (pend |=> s_q.pend)
    else $error("pending level not registered");

  // Main scenarios.
  c_w1c_clear: cover property (flags[SFC_FLAG_DPE] ##1 flag_clr[SFC_FLAG_DPE] ##1 !flags[SFC_FLAG_DPE]);
  c_msi_sent: cover property (msi_req);
  c_perr_driven: cover property (perr_oe);
  c_bm_start: cover property (bm_start);
  c_legacy_line: cover property (|legacy_channel_interrupts);

endmodule : sfc_cmd_status_regs

`default_nettype wire

//--- verilog/sfc_pkg.sv
// Purpose: Shared constants and state types for the storage function command and status register pair.
// Assumes: Configuration accesses are dword wide with four byte enables, as on a configuration cycle.
// Notes:   The command register sits in the low half of dword 04h and the status register in the high half.

package sfc_pkg;

  // Configuration byte address width in bits (256-byte header).
  localparam int unsigned SFC_AW = 8;

  // Byte offsets of the two registers; both live in the same dword.
  localparam logic [SFC_AW-1:0] SFC_CMD_OFS = 8'h04;
  localparam logic [SFC_AW-1:0] SFC_STS_OFS = 8'h06;

  // Bit position of the status register inside the dword.
  localparam int unsigned SFC_STS_SHIFT = 16;

  // Command register field positions.
  localparam int unsigned SFC_CMD_IO_SPACE_ENABLE    = 0;
  localparam int unsigned SFC_CMD_BME     = 2;
  localparam int unsigned SFC_CMD_PER     = 6;
  localparam int unsigned SFC_CMD_INT_DIS = 10;

  // Status register field positions.
  localparam int unsigned SFC_STS_INTP = 3;
  localparam int unsigned SFC_STS_MPE  = 8;
  localparam int unsigned SFC_STS_RMA  = 13;
  localparam int unsigned SFC_STS_DPE  = 15;

  // Reset values and masks.
  localparam logic [15:0] SFC_CMD_RESET = 16'h0000;
  localparam logic [15:0] SFC_CMD_WMASK = 16'h0445;
  localparam logic [15:0] SFC_STS_RESET = 16'h02a0;
  localparam logic [15:0] SFC_STS_FIXED = 16'h02a0;
  localparam logic [15:0] SFC_STS_DYN   = 16'ha108;

  // Number of legacy channel interrupt lines.
  localparam int unsigned SFC_NCHAN = 2;

  // Sticky flags kept by the flag bank, and their indices.
  localparam int unsigned SFC_NFLAGS   = 3;
  localparam int unsigned SFC_FLAG_DPE = 0;
  localparam int unsigned SFC_FLAG_RMA = 1;
  localparam int unsigned SFC_FLAG_MPE = 2;

  // State of the flag bank.
  typedef struct packed {
    logic [SFC_NFLAGS-1:0] flag;  // Sticky event flags.
  } sfc_flag_state_t;

  // State of the register block.
  typedef struct packed {
    logic                 io_space_enable;     // I/O space decode enable.
    logic                 bus_master_enable;      // Bus master enable.
    logic                 parity_response_enable;      // Parity error response enable.
    logic                 int_dis;  // Interrupt disable.
    logic                 pend;     // Registered interrupt pending level.
    logic                 intx_n;   // Native interrupt line, active low.
    logic [SFC_NCHAN-1:0] irq;      // Legacy channel interrupts.
    logic                 msi_req;  // Message interrupt request pulse.
    logic                 perr_oe;  // Parity error pin drive.
    logic [31:0]          rdata;    // Read data.
    logic                 ack;      // Access acknowledge pulse.
  } sfc_state_t;

endpackage : sfc_pkg

//--- verilog/sfc_flag_bank.sv
// Purpose: Sticky event flags that hardware sets and software clears by writing ones.
// Assumes: Set and clear strobes come from logic on the same clock.
// Notes:   A set in the same cycle as a clear wins, so no event is lost.

`timescale 1ns/1ps
`default_nettype none

module sfc_flag_bank (
  input  wire logic                           mclk,      // Core clock.
  input  wire logic                           nrst,      // Asynchronous reset, active low.
  input  wire logic [sfc_pkg::SFC_NFLAGS-1:0] flag_set,  // Hardware set strobes.
  input  wire logic [sfc_pkg::SFC_NFLAGS-1:0] flag_clr,  // Software clear strobes.
  output logic      [sfc_pkg::SFC_NFLAGS-1:0] flag_q     // Current flag values.
);
  import sfc_pkg::*;

  sfc_flag_state_t s_q;  // Registered state.
  sfc_flag_state_t s_d;  // Next state.
  logic [SFC_NFLAGS-1:0] nxt;  // Per-flag next value.

  // Each flag follows the same equation: set wins over clear.
  for (genvar i = 0; i < SFC_NFLAGS; i++) begin : g_flag
    assign nxt[i] = flag_set[i] | (s_q.flag[i] & ~flag_clr[i]);
  end

  // Fill the next state from the per-flag equations.
  always_comb begin
    s_d      = s_q;
    s_d.flag = nxt;
  end

  // State register; flags clear at reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_q = s_q.flag;

endmodule : sfc_flag_bank

`default_nettype wire

//--- dv/sfc_host_agent.sv
// Purpose: Host configuration agent that issues reads and writes to the register pair.
// Assumes: A request starts at a falling edge, so its strobe spans exactly one rising edge.
// Notes:   Once a request ends, address and data show the inverse of their last value, never a stale copy.

`timescale 1ns/1ps
`default_nettype none

module sfc_host_agent (
  input  wire logic        mclk,       // Core clock.
  output logic             cfg_rd,     // Read strobe.
  output logic             cfg_wr,     // Write strobe.
  output logic [7:0]       cfg_addr,   // Byte address.
  output logic [3:0]       cfg_be,     // Byte enables.
  output logic [31:0]      cfg_wdata,  // Write data.
  input  wire logic [31:0] cfg_rdata,  // Read data.
  input  wire logic        cfg_ack     // Access done pulse.
);
  int ack_err = 0;  // Accesses that were never answered.

  // Lines start quiet so nothing is requested during reset.
  initial begin
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // One access; the strobe is a single-cycle pulse, so it drops before the answer is awaited.
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q);
    int n;
    @(negedge mclk);
    cfg_rd    = !wr;
    cfg_wr    = wr;
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = d;
    @(negedge mclk);
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = ~a;
    cfg_wdata = ~d;
    n = 0;
    // The wait is bounded so a silent design cannot hang the run.
    while (cfg_ack !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    if (cfg_ack !== 1'b1) ack_err++;
    q = cfg_rdata;
  endtask : access
endmodule : sfc_host_agent

`default_nettype wire

//--- dv/tb.sv
// Purpose: Self-checking bench for the command and status register pair.
// Assumes: Inputs change on the falling edge; outputs are looked at on a later falling edge.
// Notes:   Pulse outputs are counted on every rising edge so exact latency does not matter.

`timescale 1ns/1ps
`default_nettype none

module tb;
  import sfc_pkg::*;
  logic        mclk, nrst, cfg_rd, cfg_wr, cfg_ack;    // Clock, reset and strobes.
  logic [7:0]  cfg_addr;                               // Byte address.
  logic [3:0]  cfg_be;                                 // Byte enables.
  logic [31:0] cfg_wdata, cfg_rdata, q;                // Data lines and read result.
  logic        host_par_err, master_abort, backbone_perr, legacy_mode, msi_enable, bm_req, io_hit;
  logic        bm_start, io_claim, bus_master_en, perr_n_o, perr_oe, intx_n, msi_req;
  logic [1:0]  chan_irq_req, legacy_irq;               // Channel requests and legacy lines.
  int          n_fail = 0, num_checks = 0, cycles = 0, msi_cnt = 0, perr_cnt = 0;

  // Free-running 20 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  sfc_cmd_status_regs dut_u (.mclk(mclk), .nrst(nrst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .host_par_err(host_par_err), .master_abort(master_abort),
    .backbone_perr(backbone_perr), .chan_irq_req(chan_irq_req), .legacy_mode(legacy_mode),
    .msi_enable(msi_enable), .bm_req(bm_req), .io_hit(io_hit), .bm_start(bm_start),
    .io_claim(io_claim), .bus_master_en(bus_master_en), .perr_n_o(perr_n_o), .perr_oe(perr_oe),
    .intx_n(intx_n), .legacy_channel_interrupts(legacy_irq), .msi_req(msi_req));

  sfc_host_agent host_u (.mclk(mclk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));

  // Closing report; the single place where the run ends.
  task end_sim;
    n_fail += host_u.ack_err;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // Pulse counters and a cycle ceiling that cuts a hang short.
  always @(posedge mclk) begin
    cycles++;
    if (msi_req === 1'b1) msi_cnt++;
    if (perr_oe === 1'b1 && perr_n_o === 1'b0) perr_cnt++;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Dword write and compared read of the register pair.
  task automatic wr(input logic [3:0] be, input logic [31:0] d);
    host_u.access(1'b1, SFC_CMD_OFS, be, d, q);
  endtask : wr

  task automatic rd(input logic [31:0] exp);
    host_u.access(1'b0, SFC_CMD_OFS, 4'hf, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // One-cycle event pulse: host parity, master abort, backbone parity.
  task automatic ev(input logic [2:0] v);
    @(negedge mclk);
    {host_par_err, master_abort, backbone_perr} = v;
    @(negedge mclk);
    {host_par_err, master_abort, backbone_perr} = 3'b000;
    cyc(2);
  endtask : ev

  initial begin
    nrst = 1'b0;
    {host_par_err, master_abort, backbone_perr, legacy_mode, msi_enable, bm_req, io_hit} = 7'h00;
    chan_irq_req = 2'b00;
    cyc(16);
    nrst = 1'b1;
    rd(32'h02a0_0000);
    host_u.access(1'b0, 8'h08, 4'hf, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    $display("test reset_values done");
    // Every bit written to one; only the writable enables may stick.
    wr(4'hf, 32'hffff_ffff);
    rd(32'h02a0_0445);
    host_u.access(1'b1, 8'h08, 4'hf, 32'h0000_0000, q);
    rd(32'h02a0_0445);
    $display("test write_masks done");
    bm_req = 1'b1;
    io_hit = 1'b1;
    cyc(1);
    chk({29'h0, bm_start, io_claim, bus_master_en}, 32'h7);
    wr(4'h1, 32'h0000_0000);
    cyc(1);
    chk({29'h0, bm_start, io_claim, bus_master_en}, 32'h0);
    $display("test enable_gates done");
    // Parity response off: the flag still sets, the pin stays quiet.
    ev(3'b101);
    chk(perr_cnt, 0);
    rd(32'h82a0_0400);
    wr(4'h1, 32'h0000_0040);
    ev(3'b111);
    chk(perr_cnt, 1);
    rd(32'ha3a0_0440);
    wr(4'h8, 32'h0000_0000);
    rd(32'ha3a0_0440);
    wr(4'h8, 32'ha100_0000);
    rd(32'h03a0_0440);
    $display("test status_flags done");
    // Interrupts: disabled first, then native, legacy and message routes.
    chan_irq_req = 2'b01;
    cyc(3);
    chk(intx_n, 1'b1);
    rd(32'h03a8_0440);
    wr(4'h2, 32'h0000_0000);
    cyc(2);
    chk(intx_n, 1'b0);
    chan_irq_req = 2'b00;
    cyc(3);
    chk(intx_n, 1'b1);
    rd(32'h03a0_0040);
    legacy_mode = 1'b1;
    chan_irq_req = 2'b10;
    cyc(3);
    chk(legacy_irq, 2'b10);
    chan_irq_req = 2'b00;
    legacy_mode = 1'b0;
    msi_enable = 1'b1;
    cyc(3);
    msi_cnt = 0;
    chan_irq_req = 2'b01;
    cyc(3);
    chan_irq_req = 2'b00;
    cyc(3);
    chk(msi_cnt, 1);
    wr(4'h2, 32'h0000_0400);
    msi_cnt = 0;
    chan_irq_req = 2'b01;
    cyc(3);
    chk(msi_cnt, 0);
    chk(intx_n, 1'b1);
    chan_irq_req = 2'b00;
    $display("test interrupts done");
    end_sim();
  end
endmodule : tb

`default_nettype wire
